// ==== scan_seq_pkg.sv ====
// scan sequencer package: modes, field layouts, command codes, timing counts
// assumes a single 125 MHz core clock shared by every user of the package
package scan_seq_pkg;

   // ****************************************
   // configuration encodings
   // ****************************************
   localparam logic [1:0] SEQ_MODE_SINGLE = 2'h0;
   localparam logic [1:0] SEQ_MODE_SCAN = 2'h1;
   localparam logic [1:0] SEQ_MODE_BIAS_SCAN = 2'h2;
   localparam logic [1:0] CMD_MODE_POWER_DOWN = 2'h1;
   localparam logic [1:0] CMD_MODE_CALIBRATE = 2'h2;
   localparam logic [1:0] CMD_MODE_SEQUENCE = 2'h3;
   localparam logic [1:0] PSTATE_CONVERT = 2'h0;
   localparam logic [1:0] PSTATE_SLEEP = 2'h1;
   localparam logic [1:0] PSTATE_STANDBY = 2'h2;
   localparam logic [1:0] PD_FIELD_SLEEP = 2'h1;
   localparam logic [1:0] PD_FIELD_STANDBY = 2'h2;
   localparam logic [2:0] ORDER_FIRST = 3'h1;
   localparam logic [2:0] ORDER_LAST = 3'h6;
   localparam logic [2:0] ORDER_BAD_LOW = 3'h0;
   localparam logic [2:0] ORDER_BAD_HIGH = 3'h7;

   // ****************************************
   // channel map entry layout (one byte per channel)
   // ****************************************
   localparam int CH_BIAS_SEL_LSB = 6;
   localparam int CH_ORDER_LSB = 3;
   localparam int CH_ENABLE_BIT = 1;
   localparam int CH_BIAS_EN_BIT = 0;
   localparam int NUM_CHANNELS = 6;
   localparam int NUM_BIAS = 4;

   // ****************************************
   // timing: one delay step, conversion and calibration times
   // ****************************************
   localparam int CLOCK_MHZ = 125;
   localparam int DELAY_STEP_US = 4;
   localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * CLOCK_MHZ;
   localparam int CONV_CYCLES_DEFAULT = 64;
   localparam int CAL_CYCLES_DEFAULT = 256;

   // conversion command, 6 bits of mode and rate, as decoded by the serial front end
   typedef struct packed {
      logic [1:0] mode;
      logic [3:0] rate;
   } cmd_t;

   // sequencer configuration bits
   typedef struct packed {
      logic [1:0] mode;
      logic scan_ready_gating;
      logic mux_delay_enable;
      logic bias_delay_enable;
      logic [7:0] mux_delay;
      logic [7:0] bias_delay;
      logic [1:0] power_down_field;
      logic single_cycle;
      logic continuous_single_cycle;
      logic output_sequencing;
   } seq_cfg_t;

endpackage : scan_seq_pkg

// ==== delay_timer.sv ====
// delay_timer: counts a programmed number of units of a fixed cycle length
// assumes start is a one-cycle pulse; units of zero finish at once
`timescale 1ns/1ps
`default_nettype none
module delay_timer
   import scan_seq_pkg::*;
#(
   parameter int UNIT_CYCLES = DELAY_STEP_CYCLES,
   parameter int UNIT_W = 16
) (
   input wire logic clk, // core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic start, // load a new count
   input wire logic abort, // drop any count in progress
   input wire logic [UNIT_W-1:0] units, // number of units to wait
   output logic busy, // count running
   output logic done // one-cycle pulse at the end
);

   typedef struct packed {
      logic [UNIT_W-1:0] units_left;
      logic [15:0] sub;
      logic run;
      logic done;
   } timer_t;

   timer_t st_r;
   timer_t st_nxt;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (abort) begin
         st_nxt.run = 1'b0;
      end else if (start) begin
         st_nxt.units_left = units;
         st_nxt.sub = 16'h0;
         st_nxt.run = (units != '0);
         st_nxt.done = (units == '0);
      end else if (st_r.run) begin
         if (st_r.sub == 16'(UNIT_CYCLES - 1)) begin
            st_nxt.sub = 16'h0;
            st_nxt.units_left = st_r.units_left - 1'b1;
            if (st_r.units_left == UNIT_W'(1)) begin
               st_nxt.run = 1'b0;
               st_nxt.done = 1'b1;
            end
         end else begin
            st_nxt.sub = st_r.sub + 16'h1;
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy = st_r.run;
   assign done = st_r.done;

endmodule : delay_timer
`default_nettype wire

// ==== scan_sequencer.sv ====
// scan_sequencer: multichannel scan sequencer with bias output switching
// assumes the serial front end hands over decoded commands as one-cycle pulses
// and that the analog converter reports each result with a done pulse
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R01: mode 01 scans without bias switching
// R02: mode 10 scans with bias switching
// R03: gating bit delays ready until scan end
// R04: mux delay before each conversion when enabled
// R05: enabled channels only, order 001 to 110
// R06: power-down command aborts scan into chosen state
// R07: host starts scan with mode 11
// R08: per-channel ready flag on result stored
// R09: mode 01 sleeps after last channel
// R10: mode 01 pins follow direction registers
// R11: output sequencing on: sequencer drives bias
// R12: output sequencing off: registers drive bias
// R13: channel's bias pin on during its turn
// R14: bias delay before mux select when enabled
// R15: mode 10 sleeps after last channel
// R16: continuous bit ignored; single cycle required (the single_cycle bit is not checked)
// R17: flag shared bias mapping
// R18: flag enabled channel with order 000/111
// R19: decode power-down, calibrate, sequence commands
// R20: power state 00 while converting
// R21: bias, bias delay, mux delay, convert
module scan_sequencer
   import scan_seq_pkg::*;
#(
   parameter int NCH = NUM_CHANNELS,
   parameter int NBIAS = NUM_BIAS,
   parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT
) (
   input wire logic CLOCK, // core clock, 125 MHz
   input wire logic RST_N, // synchronous reset, active low
   input wire seq_cfg_t CFG, // sequencer configuration bits
   input wire logic [8*NCH-1:0] CHANNEL_MAP, // channel map, one byte per channel
   input wire logic [NBIAS-1:0] OUTPUT_DIRECTION, // direct bias pin levels
   input wire logic CMD_VALID, // conversion command pulse
   input wire cmd_t CMD, // decoded conversion command
   input wire logic CONV_DONE, // converter finished one result
   input wire logic [23:0] CONV_DATA, // converter result
   input wire logic STATUS_CLEAR, // scan ready flags cleared by status read
   output logic [2:0] MUX_SELECT, // multiplexer channel
   output logic MUX_ENABLE, // multiplexer connected
   output logic CONV_START, // start one conversion, pulse
   output logic [3:0] CONV_RATE, // data rate for the converter
   output logic [NBIAS-1:0] BIAS_OUTPUT, // bias pin levels
   output logic DATA_READY_N, // data ready, active low
   output logic [NCH-1:0] SCAN_READY_FLAGS, // per channel result available
   output logic [24*NCH-1:0] RESULTS, // per channel result registers
   output logic [1:0] POWER_STATE_FIELD, // power state
   output logic OUTPUT_MAPPING_ERROR, // shared bias mapping
   output logic ORDER_ERROR, // bad order on enabled channel
   output logic CAL_BUSY // calibration running
);

   typedef enum {
      S_IDLE, S_NEXT, S_BIAS_WAIT, S_MUX_WAIT, S_CONVERT, S_CAL
   } phase_t;

   typedef struct packed {
      phase_t phase;
      logic [2:0] order;
      logic [2:0] chan;
      logic [1:0] mode;
      logic [3:0] rate;
      logic [1:0] pstate;
      logic [NCH-1:0] flags;
      logic [24*NCH-1:0] results;
      logic [NBIAS-1:0] seq_bias;
      logic ready_n;
      logic conv_start;
      logic [15:0] cal_cnt;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   logic tmr_start;
   logic tmr_abort;
   logic [15:0] tmr_units;
   logic tmr_done;
   logic found_end;
   logic abort_cmd;
   logic [NCH-1:0] enabled;

   // ****************************************
   // helpers on the channel map
   // ****************************************
   function automatic logic [2:0] ch_order(input logic [8*NCH-1:0] m, input int n);
      ch_order = m[8*n+CH_ORDER_LSB +: 3];
   endfunction : ch_order

   function automatic logic [1:0] ch_bias(input logic [8*NCH-1:0] m, input int n);
      ch_bias = m[8*n+CH_BIAS_SEL_LSB +: 2];
   endfunction : ch_bias

   // find the enabled channel carrying the lowest order value at or above a start
   function automatic logic [3:0] find_chan(input logic [8*NCH-1:0] m,
                                            input logic [NCH-1:0] en,
                                            input logic [2:0] from);
      logic [3:0] best;
      logic [2:0] best_ord;
      best = 4'h8;
      best_ord = ORDER_BAD_HIGH;
      for (int n = 0; n < NCH; n++) begin
         if (en[n] && ch_order(m, n) >= from && ch_order(m, n) <= ORDER_LAST &&
             ch_order(m, n) < best_ord) begin
            best = 4'(n);
            best_ord = ch_order(m, n);
         end
      end
      find_chan = best;
   endfunction : find_chan

   always_comb begin
      for (int n = 0; n < NCH; n++) begin
         enabled[n] = CHANNEL_MAP[8*n+CH_ENABLE_BIT];
      end
   end

   // ****************************************
   // map error checking
   // ****************************************
   always_comb begin
      ORDER_ERROR = 1'b0;
      OUTPUT_MAPPING_ERROR = 1'b0;
      for (int n = 0; n < NCH; n++) begin
         if (enabled[n] && (ch_order(CHANNEL_MAP, n) == ORDER_BAD_LOW ||
                            ch_order(CHANNEL_MAP, n) == ORDER_BAD_HIGH)) begin
            ORDER_ERROR = 1'b1; // R18
         end
         for (int k = n + 1; k < NCH; k++) begin
            if (CHANNEL_MAP[8*n+CH_BIAS_EN_BIT] && CHANNEL_MAP[8*k+CH_BIAS_EN_BIT] &&
                ch_bias(CHANNEL_MAP, n) == ch_bias(CHANNEL_MAP, k)) begin
               OUTPUT_MAPPING_ERROR = 1'b1; // R17
            end
         end
      end
   end

   assign abort_cmd = CMD_VALID && CMD.mode == CMD_MODE_POWER_DOWN; // R19

   // ****************************************
   // sequencer next state
   // ****************************************
   always_comb begin
      logic [3:0] found;
      found = 4'h8;
      st_nxt = st_r;
      st_nxt.conv_start = 1'b0;
      tmr_start = 1'b0;
      tmr_abort = 1'b0;
      tmr_units = 16'h0;
      if (STATUS_CLEAR) begin
         st_nxt.flags = '0;
      end
      if (abort_cmd) begin
         // power-down aborts any activity into the chosen exit state
         tmr_abort = 1'b1; // R06
         st_nxt.phase = S_IDLE;
         st_nxt.seq_bias = '0;
         st_nxt.pstate = (CFG.power_down_field == PD_FIELD_STANDBY) ?
                         PSTATE_STANDBY : PSTATE_SLEEP;
      end else begin
         case (st_r.phase)
            S_IDLE: begin
               // continuous single cycle bit is not looked at in scan modes
               if (CMD_VALID && CMD.mode == CMD_MODE_SEQUENCE &&
                   (CFG.mode == SEQ_MODE_SCAN || CFG.mode == SEQ_MODE_BIAS_SCAN)) begin // R07 R16
                  st_nxt.mode = CFG.mode; // R01 R02
                  st_nxt.rate = CMD.rate;
                  st_nxt.order = ORDER_FIRST;
                  st_nxt.flags = '0;
                  st_nxt.pstate = PSTATE_CONVERT; // R20
                  st_nxt.phase = S_NEXT;
               end else if (CMD_VALID && CMD.mode == CMD_MODE_CALIBRATE) begin
                  st_nxt.cal_cnt = 16'(CAL_CYCLES);
                  st_nxt.pstate = PSTATE_CONVERT;
                  st_nxt.phase = S_CAL; // R19
               end
            end
            S_NEXT: begin
               found = find_chan(CHANNEL_MAP, enabled, st_r.order); // R05
               if (found[3]) begin
                  // scan complete: sleep in both scan modes
                  st_nxt.phase = S_IDLE;
                  st_nxt.seq_bias = '0;
                  st_nxt.pstate = PSTATE_SLEEP; // R09 R15
               end else begin
                  st_nxt.chan = found[2:0];
                  st_nxt.order = ch_order(CHANNEL_MAP, int'(found[2:0])) + 3'h1;
                  st_nxt.seq_bias = '0;
                  if (st_r.mode == SEQ_MODE_BIAS_SCAN &&
                      CHANNEL_MAP[8*int'(found[2:0])+CH_BIAS_EN_BIT]) begin
                     st_nxt.seq_bias[ch_bias(CHANNEL_MAP, int'(found[2:0]))] = 1'b1; // R13 R21
                  end
                  if (st_r.mode == SEQ_MODE_BIAS_SCAN && CFG.bias_delay_enable) begin
                     tmr_start = 1'b1;
                     tmr_units = {8'h0, CFG.bias_delay}; // R14
                     st_nxt.phase = S_BIAS_WAIT;
                  end else begin
                     tmr_start = 1'b1;
                     tmr_units = CFG.mux_delay_enable ? {8'h0, CFG.mux_delay} : 16'h0; // R04
                     st_nxt.phase = S_MUX_WAIT;
                  end
               end
            end
            S_BIAS_WAIT: begin
               if (tmr_done) begin
                  tmr_start = 1'b1;
                  tmr_units = CFG.mux_delay_enable ? {8'h0, CFG.mux_delay} : 16'h0; // R21
                  st_nxt.phase = S_MUX_WAIT;
               end
            end
            S_MUX_WAIT: begin
               if (tmr_done) begin
                  st_nxt.conv_start = 1'b1;
                  st_nxt.phase = S_CONVERT;
               end
            end
            S_CONVERT: begin
               if (CONV_DONE) begin
                  st_nxt.results[24*int'(st_r.chan) +: 24] = CONV_DATA;
                  st_nxt.flags[st_r.chan] = 1'b1; // R08
                  st_nxt.phase = S_NEXT;
               end
            end
            S_CAL: begin
               st_nxt.cal_cnt = st_r.cal_cnt - 16'h1;
               if (st_r.cal_cnt == 16'h1) begin
                  st_nxt.phase = S_IDLE;
                  st_nxt.pstate = (CFG.power_down_field == PD_FIELD_STANDBY) ?
                                  PSTATE_STANDBY : PSTATE_SLEEP;
               end
            end
            default: begin
               st_nxt.phase = S_IDLE;
            end
         endcase
      end
      // data ready: low per result, or once at scan end when gated
      if (st_r.phase == S_CONVERT && CONV_DONE && !abort_cmd) begin
         st_nxt.ready_n = CFG.scan_ready_gating; // R03
      end else if (st_r.phase == S_NEXT && found[3] && !abort_cmd) begin
         st_nxt.ready_n = 1'b0; // R03
      end else if (STATUS_CLEAR || (CMD_VALID && CMD.mode == CMD_MODE_SEQUENCE)) begin
         st_nxt.ready_n = 1'b1;
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         st_r <= '0;
         st_r.phase <= S_IDLE;
         st_r.pstate <= PSTATE_STANDBY;
         st_r.ready_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // settling delays, one instance shared by bias and mux phases
   delay_timer #(
      .UNIT_CYCLES(DELAY_STEP_CYCLES),
      .UNIT_W(16)
   ) u_delay (
      .clk(CLOCK),
      .rst_n(RST_N),
      .start(tmr_start),
      .abort(tmr_abort),
      .units(tmr_units),
      .busy(),
      .done(tmr_done)
   );

   // ****************************************
   // outputs
   // ****************************************
   always_comb begin
      // sequencer owns bias pins only in bias scan with sequencing on
      if (st_r.phase != S_IDLE && st_r.phase != S_CAL &&
          st_r.mode == SEQ_MODE_BIAS_SCAN && CFG.output_sequencing) begin
         BIAS_OUTPUT = st_r.seq_bias; // R11
      end else begin
         BIAS_OUTPUT = OUTPUT_DIRECTION; // R10 R12
      end
   end

   assign MUX_SELECT = st_r.chan;
   assign MUX_ENABLE = (st_r.phase == S_MUX_WAIT || st_r.phase == S_CONVERT);
   assign CONV_START = st_r.conv_start;
   assign CONV_RATE = st_r.rate;
   assign DATA_READY_N = st_r.ready_n;
   assign SCAN_READY_FLAGS = st_r.flags;
   assign RESULTS = st_r.results;
   assign POWER_STATE_FIELD = st_r.pstate;
   assign CAL_BUSY = (st_r.phase == S_CAL);

   // ****************************************
   // checks
   // ****************************************
   property p_power_abort;
      @(posedge CLOCK) disable iff (!RST_N)
      abort_cmd |=> (POWER_STATE_FIELD != PSTATE_CONVERT) && st_r.phase == S_IDLE;
   endproperty
   a_power_abort: assert property (p_power_abort) else $error("abort not taken"); // R06

   property p_start_conv;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.phase == S_IDLE && CMD_VALID && CMD.mode == CMD_MODE_SEQUENCE &&
       CFG.mode == SEQ_MODE_SCAN) |=> POWER_STATE_FIELD == PSTATE_CONVERT;
   endproperty
   a_start_conv: assert property (p_start_conv) else $error("scan did not start"); // R20

   property p_flag_set;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.phase == S_CONVERT && CONV_DONE && !abort_cmd) |=> SCAN_READY_FLAGS[$past(st_r.chan)];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("ready flag missing"); // R08

   property p_gated_ready;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.phase == S_CONVERT && CONV_DONE && CFG.scan_ready_gating && !abort_cmd)
      |=> DATA_READY_N == $past(DATA_READY_N);
   endproperty
   a_gated_ready: assert property (p_gated_ready) else $error("ready not gated"); // R03

   property p_bias_owner;
      @(posedge CLOCK) disable iff (!RST_N)
      !CFG.output_sequencing |-> BIAS_OUTPUT == OUTPUT_DIRECTION;
   endproperty
   a_bias_owner: assert property (p_bias_owner) else $error("bias not from registers"); // R12

   property p_scan_end_sleep;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.phase == S_NEXT && found_end && !abort_cmd) |=>
      POWER_STATE_FIELD == PSTATE_SLEEP && st_r.phase == S_IDLE;
   endproperty
   a_scan_end_sleep: assert property (p_scan_end_sleep) else $error("no sleep at end"); // R09

   property p_order_err;
      @(posedge CLOCK) disable iff (!RST_N)
      (enabled[0] && ch_order(CHANNEL_MAP, 0) == ORDER_BAD_HIGH) |-> ORDER_ERROR;
   endproperty
   a_order_err: assert property (p_order_err) else $error("order error missed"); // R18

   property p_mux_delay;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.phase == S_NEXT && tmr_start && tmr_units == 16'h0 && !abort_cmd &&
       st_nxt.phase == S_MUX_WAIT) |=>
      ##1 CONV_START;
   endproperty
   a_mux_delay: assert property (p_mux_delay) else $error("conversion start late"); // R04

   assign found_end = find_chan(CHANNEL_MAP, enabled, st_r.order) == 4'h8;

endmodule : scan_sequencer
`default_nettype wire

// ==== conv_model.sv ====
// conv_model: behavioural converter on the far side of the sequencer
// assumes one conversion at a time; logs the select and bias seen at each of the first 8 starts
`timescale 1ns/1ps
`default_nettype none
module conv_model
   import scan_seq_pkg::*;
(
   input wire logic CLOCK, // core clock
   input wire logic CONV_START, // conversion start pulse
   input wire logic [2:0] MUX_SELECT, // selected channel
   input wire logic [3:0] BIAS_OUTPUT, // bias pins at start
   output logic CONV_DONE, // result pulse
   output logic [23:0] CONV_DATA // result, toggles when not valid
);
   int lat = 20;
   int n = 0;
   int cnt = 0;
   logic [2:0] cur = 3'h0;
   logic [2:0] sel_log [0:7];
   logic [3:0] bias_log [0:7];
   initial begin
      CONV_DONE = 1'b0;
      CONV_DATA = 24'h000000;
   end
   // answer each start after lat cycles; data toggles outside the done cycle
   always @(posedge CLOCK) begin
      CONV_DONE <= #1 1'b0;
      CONV_DATA <= #1 ~CONV_DATA;
      if (cnt == 1) begin
         CONV_DONE <= #1 1'b1;
         CONV_DATA <= #1 {21'h0b4000, cur};
      end
      if (cnt > 0) cnt = cnt - 1;
      if (CONV_START === 1'b1) begin
         cur = MUX_SELECT;
         cnt = lat;
         if (n < 8) begin
            sel_log[n] = MUX_SELECT;
            bias_log[n] = BIAS_OUTPUT;
         end
         n = n + 1;
      end
   end
endmodule : conv_model
`default_nettype wire

// ==== adc_scan_sequencer_bench.sv ====
// adc_scan_sequencer_bench: command sequences against scan_sequencer
// assumes conv_model answers conversions; inputs change 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module adc_scan_sequencer_bench
   import scan_seq_pkg::*;
;
   logic CLOCK = 0, RST_N = 0, CMD_VALID = 0, STATUS_CLEAR = 0;
   seq_cfg_t cfg = '0;
   cmd_t cmd = '0;
   logic [47:0] map = '0;
   logic [3:0] odir = 4'h0, rate, bias;
   logic [2:0] msel;
   logic [5:0] flags;
   logic [143:0] res;
   logic [1:0] pst;
   logic [23:0] cdata;
   logic men, cstart, drdy_n, map_err, ord_err, cal_busy, cdone;
   logic [15:0] tbl [0:4];
   logic [1:0] texp [0:4];
   int error_cnt = 0, checks_done = 0, t, first, early;
   initial begin
      forever #4 CLOCK = ~CLOCK;
   end
   scan_sequencer #(.CAL_CYCLES(32)) uut (.CLOCK(CLOCK), .RST_N(RST_N), .CFG(cfg),
      .CHANNEL_MAP(map), .OUTPUT_DIRECTION(odir), .CMD_VALID(CMD_VALID), .CMD(cmd),
      .CONV_DONE(cdone), .CONV_DATA(cdata), .STATUS_CLEAR(STATUS_CLEAR), .MUX_SELECT(msel),
      .MUX_ENABLE(men), .CONV_START(cstart), .CONV_RATE(rate), .BIAS_OUTPUT(bias),
      .DATA_READY_N(drdy_n), .SCAN_READY_FLAGS(flags), .RESULTS(res),
      .POWER_STATE_FIELD(pst), .OUTPUT_MAPPING_ERROR(map_err), .ORDER_ERROR(ord_err),
      .CAL_BUSY(cal_busy));
   conv_model model (.CLOCK(CLOCK), .CONV_START(cstart), .MUX_SELECT(msel),
      .BIAS_OUTPUT(bias), .CONV_DONE(cdone), .CONV_DATA(cdata));
   // ****************************************
   // tasks
   // ****************************************
   task check_val(input string nm, input logic [47:0] exp, input logic [47:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check_val
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   task tick(input int k);
      repeat (k) @(posedge CLOCK);
      #1;
   endtask : tick
   function logic [7:0] ent(input logic [1:0] b, input logic [2:0] o, input logic e,
                            input logic be);
      return {b, o, 1'b0, e, be};
   endfunction : ent
   task cmd_go(input logic [1:0] m);
      tick(1);
      cmd = '{mode: m, rate: 4'h9};
      CMD_VALID = 1'b1;
      tick(1);
      CMD_VALID = 1'b0;
   endtask : cmd_go
   // start a scan, wait for sleep, then compare the converter's log
   task scan(input int cnt, input logic [11:0] sels, input logic [15:0] bs);
      model.n = 0;
      cmd_go(CMD_MODE_SEQUENCE);
      tick(1);
      check_val("power state", PSTATE_CONVERT, pst);
      t = 0;
      first = -1;
      early = 0;
      while (pst !== PSTATE_SLEEP && t < 5000) begin
         if (drdy_n === 1'b0) early = 1;
         if (cstart === 1'b1 && first < 0) first = t;
         if (cstart === 1'b1) check_val("mux enable", 1'b1, men);
         tick(1);
         t++;
      end
      if (t >= 5000) begin
         error_cnt++;
         $display("wrong value scan end expected sleep seen %h", pst);
         wrap_up();
      end
      check_val("conversions", cnt, model.n);
      for (int i = 0; i < cnt; i++) begin
         check_val("select", sels[3*i+:3], model.sel_log[i]);
         check_val("bias", bs[4*i+:4], model.bias_log[i]);
      end
      check_val("rate", 4'h9, rate);
      check_val("ready", 1'b0, drdy_n);
   endtask : scan
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      cfg.single_cycle = 1'b1;
      tick(5);
      RST_N = 1'b1;
      tick(1);
      check_val("reset state", {PSTATE_STANDBY, 1'b1, 6'h00}, {pst, drdy_n, flags});
      $display("test reset done");
      map = {ent(0, 4, 0, 0), ent(2, 3, 1, 0), ent(0, 0, 0, 0), ent(0, 1, 1, 1),
             ent(3, 6, 1, 1), ent(1, 2, 1, 1)};
      odir = 4'h9;
      cfg.mode = SEQ_MODE_SCAN;
      scan(4, {3'h1, 3'h4, 3'h0, 3'h2}, 16'h9999);
      check_val("flags", 6'h17, flags);
      check_val("errors", 2'b00, {ord_err, map_err});
      for (int c = 0; c < 5; c++)
         if (c != 3) check_val("result", {21'h0b4000, c[2:0]}, res[24*c+:24]);
      STATUS_CLEAR = 1'b1;
      tick(1);
      STATUS_CLEAR = 1'b0;
      tick(1);
      check_val("cleared", {1'b1, 6'h00}, {drdy_n, flags});
      $display("test plain scan done");
      map = {24'h0, ent(0, 2, 1, 1), ent(1, 1, 1, 1), ent(2, 3, 1, 1)};
      odir = 4'h8;
      cfg = '{mode: SEQ_MODE_BIAS_SCAN, scan_ready_gating: 1, mux_delay_enable: 1,
             bias_delay_enable: 1, mux_delay: 1, bias_delay: 1, power_down_field: 1,
             single_cycle: 1, continuous_single_cycle: 1, output_sequencing: 1};
      scan(3, {3'h0, 3'h0, 3'h2, 3'h1}, 16'h0412);
      check_val("gated ready", 0, early);
      check_val("delays", 1, first >= 998 && first <= 1010);
      check_val("flags", 6'h07, flags);
      cfg = '{mode: SEQ_MODE_BIAS_SCAN, power_down_field: 1, single_cycle: 1, default: 0};
      odir = 4'h6;
      scan(3, {3'h0, 3'h0, 3'h2, 3'h1}, 16'h0666);
      $display("test bias scan done");
      model.lat = 300;
      for (int k = 0; k < 2; k++) begin
         cfg.power_down_field = k ? PD_FIELD_SLEEP : PD_FIELD_STANDBY;
         model.n = 0;
         cmd_go(CMD_MODE_SEQUENCE);
         t = 0;
         while (model.n == 0 && t < 2000) begin
            tick(1);
            t++;
         end
         if (t >= 2000) begin
            error_cnt++;
            $display("wrong value abort start expected conversion seen none");
            wrap_up();
         end
         cmd_go(CMD_MODE_POWER_DOWN);
         tick(1);
         check_val("abort state", k ? PSTATE_SLEEP : PSTATE_STANDBY, pst);
         tick(320);
         check_val("after abort", 1, model.n);
      end
      model.lat = 20;
      $display("test abort done");
      cmd_go(2'h0);
      tick(1);
      check_val("unused cmd", PSTATE_SLEEP, pst);
      cmd_go(CMD_MODE_CALIBRATE);
      tick(1);
      check_val("cal busy", 1'b1, cal_busy);
      tick(40);
      check_val("cal end", 1'b0, cal_busy);
      $display("test commands done");
      tbl = '{{8'h0, ent(0, 0, 1, 0)}, {8'h0, ent(0, 7, 1, 0)}, {8'h0, ent(0, 7, 0, 0)},
              {ent(1, 2, 1, 1), ent(1, 1, 1, 1)}, {ent(2, 2, 1, 1), ent(1, 1, 1, 1)}};
      texp = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b00};
      for (int i = 0; i < 5; i++) begin
         map = {32'h0, tbl[i]};
         tick(1);
         check_val("map errors", texp[i], {ord_err, map_err});
      end
      $display("test map errors done");
      wrap_up();
   end
endmodule : adc_scan_sequencer_bench
`default_nettype wire
